// [rtl/sqsti_defs.svh]
`ifndef SQSTI_DEFS_SVH
`define SQSTI_DEFS_SVH
// enable handshake delay; ack follows an enable change this many cycles plus one in sqsti_world, plus two at the sqsti_init_regs outputs
`define SQSTI_ACK_DELAY     4
// largest queue size field value; the field is log2 of entry count minus 1
`define SQSTI_LOG2_MAX      5'h13
// zero index value
`define SQSTI_IDX_ZERO      20'h00000
// reset values
`define SQSTI_CFG_RESET     32'h00000000
`define SQSTI_BASE_RESET    64'h0000000000000000
// stream table entry valid bit position
`define SQSTI_ENTRY_VALID_BIT 0
`endif

// [rtl/sqsti_pkg.sv]
package sqsti_pkg;
	typedef enum logic [1:0] {
		SQSTI_IDLE,
		SQSTI_BUSY
	} sqsti_ack_e;
	typedef logic [19:0] sqsti_idx_t;
endpackage

// [rtl/sqsti_world.sv]
`timescale 1ns/1ps
`include "sqsti_defs.svh"
module sqsti_world
	import sqsti_pkg::*;
#(
	parameter int IDX_W     = 20,
	parameter int ACK_DELAY = `SQSTI_ACK_DELAY
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// command queue registers
	input  wire logic              cmdBaseWr,
	input  wire logic [63:0]       cmdBaseData,
	input  wire logic [4:0]        cmdLog2Size,
	input  wire logic              cmdReadWr,
	input  wire logic              cmdWriteWr,
	input  wire logic [IDX_W-1:0]  cmdIdxData,
	// event queue registers
	input  wire logic              evtBaseWr,
	input  wire logic [63:0]       evtBaseData,
	input  wire logic [4:0]        evtLog2Size,
	input  wire logic              evtReadWr,
	input  wire logic              evtWriteWr,
	input  wire logic [IDX_W-1:0]  evtIdxData,
	// device side index movement
	input  wire logic              cmdConsume,
	input  wire logic              evtProduce,
	// stream table
	input  wire logic              stCfgWr,
	input  wire logic [31:0]       stCfgData,
	input  wire logic              stBaseWr,
	input  wire logic [63:0]       stBaseData,
	// control
	input  wire logic              cmdQueueEnable,
	input  wire logic              evtQueueEnable,
	// state
	output logic [63:0]            cmdBase,
	output logic [IDX_W-1:0]       cmdReadIdx,
	output logic [IDX_W-1:0]       cmdWriteIdx,
	output logic [63:0]            evtBase,
	output logic [IDX_W-1:0]       evtReadIdx,
	output logic [IDX_W-1:0]       evtWriteIdx,
	output logic [31:0]            stCfg,
	output logic [63:0]            stBase,
	output logic                   cmdEmpty,
	output logic                   evtEmpty,
	output logic                   cmdAck,
	output logic                   evtAck
);
	if (IDX_W < 2 || IDX_W > 20 || ACK_DELAY < 1 || ACK_DELAY > 255) begin : g_bad_param
		$error("sqsti_world: bad parameters");
	end
	// ***********************************
	// queue registers
	// ***********************************
	logic [4:0]       cmdLog2;
	logic [4:0]       evtLog2;
	logic [4:0]       next_cmdLog2;
	logic [4:0]       next_evtLog2;
	logic [63:0]      next_cmdBase;
	logic [63:0]      next_evtBase;
	logic [IDX_W-1:0] next_cmdReadIdx;
	logic [IDX_W-1:0] next_cmdWriteIdx;
	logic [IDX_W-1:0] next_evtReadIdx;
	logic [IDX_W-1:0] next_evtWriteIdx;
	logic [31:0]      next_stCfg;
	logic [63:0]      next_stBase;
	logic [IDX_W-1:0] cmdMask;
	logic [IDX_W-1:0] evtMask;
	logic [IDX_W-1:0] cmdWrap;
	logic [IDX_W-1:0] evtWrap;

	function automatic logic [IDX_W-1:0] sizeMask(input logic [4:0] l2);
		logic [IDX_W-1:0] m;
		m = '0;
		for (int i = 0; i < IDX_W; i++) begin
			if (i <= int'(l2))
				m[i] = 1'b1;
		end
		return m;
	endfunction

	always_comb begin
		cmdMask          = sizeMask(cmdLog2);
		evtMask          = sizeMask(evtLog2);
		cmdWrap          = IDX_W'(cmdReadIdx + 1'b1) & cmdMask;
		evtWrap          = IDX_W'(evtWriteIdx + 1'b1) & evtMask;
		next_cmdLog2     = cmdLog2;
		next_evtLog2     = evtLog2;
		next_cmdBase     = cmdBase;
		next_evtBase     = evtBase;
		next_cmdReadIdx  = cmdReadIdx;
		next_cmdWriteIdx = cmdWriteIdx;
		next_evtReadIdx  = evtReadIdx;
		next_evtWriteIdx = evtWriteIdx;
		next_stCfg       = stCfg;
		next_stBase      = stBase;
		if (cmdBaseWr) begin
			next_cmdBase = cmdBaseData;
			next_cmdLog2 = (cmdLog2Size > `SQSTI_LOG2_MAX) ? `SQSTI_LOG2_MAX : cmdLog2Size;
		end
		if (evtBaseWr) begin
			next_evtBase = evtBaseData;
			next_evtLog2 = (evtLog2Size > `SQSTI_LOG2_MAX) ? `SQSTI_LOG2_MAX : evtLog2Size;
		end
		if (cmdConsume && !cmdEmpty && cmdAck)
			next_cmdReadIdx = cmdWrap;
		if (cmdReadWr)
			next_cmdReadIdx = cmdIdxData & cmdMask;
		if (cmdWriteWr)
			next_cmdWriteIdx = cmdIdxData & cmdMask;
		if (evtProduce && evtAck)
			next_evtWriteIdx = evtWrap;
		if (evtReadWr)
			next_evtReadIdx = evtIdxData & evtMask;
		if (evtWriteWr)
			next_evtWriteIdx = evtIdxData & evtMask;
		if (stCfgWr)
			next_stCfg = stCfgData;
		if (stBaseWr)
			next_stBase = stBaseData;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmdLog2     <= 5'h00;
			evtLog2     <= 5'h00;
			cmdBase     <= `SQSTI_BASE_RESET;
			evtBase     <= `SQSTI_BASE_RESET;
			cmdReadIdx  <= '0;
			cmdWriteIdx <= '0;
			evtReadIdx  <= '0;
			evtWriteIdx <= '0;
			stCfg       <= `SQSTI_CFG_RESET;
			stBase      <= `SQSTI_BASE_RESET;
		end else begin
			cmdLog2     <= next_cmdLog2;
			evtLog2     <= next_evtLog2;
			cmdBase     <= next_cmdBase;
			evtBase     <= next_evtBase;
			cmdReadIdx  <= next_cmdReadIdx;
			cmdWriteIdx <= next_cmdWriteIdx;
			evtReadIdx  <= next_evtReadIdx;
			evtWriteIdx <= next_evtWriteIdx;
			stCfg       <= next_stCfg;
			stBase      <= next_stBase;
		end
	end

	assign cmdEmpty = (cmdReadIdx == cmdWriteIdx);
	assign evtEmpty = (evtReadIdx == evtWriteIdx);

	// ***********************************
	// enable acknowledge
	// ***********************************
	sqsti_ack_e  cmdState;
	sqsti_ack_e  evtState;
	sqsti_ack_e  next_cmdState;
	sqsti_ack_e  next_evtState;
	logic [7:0]  cmdCnt;
	logic [7:0]  evtCnt;
	logic [7:0]  next_cmdCnt;
	logic [7:0]  next_evtCnt;
	logic        next_cmdAck;
	logic        next_evtAck;

	always_comb begin
		next_cmdState = cmdState;
		next_cmdCnt   = cmdCnt;
		next_cmdAck   = cmdAck;
		unique case (cmdState)
			SQSTI_IDLE: begin
				if (cmdQueueEnable != cmdAck) begin
					next_cmdState = SQSTI_BUSY;
					next_cmdCnt   = 8'(ACK_DELAY - 1);
				end
			end
			SQSTI_BUSY: begin
				if (cmdQueueEnable == cmdAck)
					next_cmdState = SQSTI_IDLE;
				else if (cmdCnt == 8'h00) begin
					next_cmdAck   = cmdQueueEnable;
					next_cmdState = SQSTI_IDLE;
				end else
					next_cmdCnt = cmdCnt - 8'h01;
			end
		endcase
	end

	always_comb begin
		next_evtState = evtState;
		next_evtCnt   = evtCnt;
		next_evtAck   = evtAck;
		unique case (evtState)
			SQSTI_IDLE: begin
				if (evtQueueEnable != evtAck) begin
					next_evtState = SQSTI_BUSY;
					next_evtCnt   = 8'(ACK_DELAY - 1);
				end
			end
			SQSTI_BUSY: begin
				if (evtQueueEnable == evtAck)
					next_evtState = SQSTI_IDLE;
				else if (evtCnt == 8'h00) begin
					next_evtAck   = evtQueueEnable;
					next_evtState = SQSTI_IDLE;
				end else
					next_evtCnt = evtCnt - 8'h01;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmdState <= SQSTI_IDLE;
			evtState <= SQSTI_IDLE;
			cmdCnt   <= 8'h00;
			evtCnt   <= 8'h00;
			cmdAck   <= 1'b0;
			evtAck   <= 1'b0;
		end else begin
			cmdState <= next_cmdState;
			evtState <= next_evtState;
			cmdCnt   <= next_cmdCnt;
			evtCnt   <= next_evtCnt;
			cmdAck   <= next_cmdAck;
			evtAck   <= next_evtAck;
		end
	end
endmodule

// [rtl/sqsti_init_regs.sv]
`timescale 1ns/1ps
`include "sqsti_defs.svh"
module sqsti_init_regs
	import sqsti_pkg::*;
#(
	parameter int IDX_W     = 20,
	parameter int ACK_DELAY = `SQSTI_ACK_DELAY,
	parameter bit COHERENT  = 1'b0
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// world select for writes, 1 selects secure
	input  wire logic              secureSel,
	// queue register writes
	input  wire logic              cmdBaseWr,
	input  wire logic [63:0]       cmdBaseData,
	input  wire logic [4:0]        cmdLog2Size,
	input  wire logic              cmdReadWr,
	input  wire logic              cmdWriteWr,
	input  wire logic [IDX_W-1:0]  cmdIdxData,
	input  wire logic              evtBaseWr,
	input  wire logic [63:0]       evtBaseData,
	input  wire logic [4:0]        evtLog2Size,
	input  wire logic              evtReadWr,
	input  wire logic              evtWriteWr,
	input  wire logic [IDX_W-1:0]  evtIdxData,
	// device side queue movement, per world
	input  wire logic [1:0]        cmdConsume,
	input  wire logic [1:0]        evtProduce,
	// stream table writes
	input  wire logic              stCfgWr,
	input  wire logic [31:0]       stCfgData,
	input  wire logic              stBaseWr,
	input  wire logic [63:0]       stBaseData,
	// fetched stream table entry word
	input  wire logic [63:0]       entryWord,
	// control register bits, per world
	input  wire logic [1:0]        cmdQueueEnable,
	input  wire logic [1:0]        evtQueueEnable,
	// status, index 0 non-secure, 1 secure
	output logic [1:0]             cmdAck,
	output logic [1:0]             evtAck,
	output logic [1:0]             cmdEmpty,
	output logic [1:0]             evtEmpty,
	output logic [1:0]             cmdPending,
	output logic [2*IDX_W-1:0]     cmdReadIdx,
	output logic [2*IDX_W-1:0]     cmdWriteIdx,
	output logic [2*IDX_W-1:0]     evtReadIdx,
	output logic [2*IDX_W-1:0]     evtWriteIdx,
	output logic [127:0]           cmdBase,
	output logic [127:0]           evtBase,
	output logic [63:0]            stCfg,
	output logic [127:0]           stBase,
	output logic                   entryInvalid,
	output logic                   coherentAccess
);
	// ***********************************
	// two worlds
	// ***********************************
	logic [1:0]         wAck_c;
	logic [1:0]         wAck_e;
	logic [1:0]         wEmp_c;
	logic [1:0]         wEmp_e;
	logic [2*IDX_W-1:0] wCr;
	logic [2*IDX_W-1:0] wCw;
	logic [2*IDX_W-1:0] wEr;
	logic [2*IDX_W-1:0] wEw;
	logic [127:0]       wCb;
	logic [127:0]       wEb;
	logic [63:0]        wSc;
	logic [127:0]       wSb;

	for (genvar w = 0; w < 2; w++) begin : g_world
		logic sel;
		assign sel = (secureSel == 1'(w));
		sqsti_world #(.IDX_W(IDX_W), .ACK_DELAY(ACK_DELAY)) u_world (
			.clock          (clock),
			.rst_n          (rst_n),
			.cmdBaseWr      (cmdBaseWr && sel),
			.cmdBaseData    (cmdBaseData),
			.cmdLog2Size    (cmdLog2Size),
			.cmdReadWr      (cmdReadWr && sel),
			.cmdWriteWr     (cmdWriteWr && sel),
			.cmdIdxData     (cmdIdxData),
			.evtBaseWr      (evtBaseWr && sel),
			.evtBaseData    (evtBaseData),
			.evtLog2Size    (evtLog2Size),
			.evtReadWr      (evtReadWr && sel),
			.evtWriteWr     (evtWriteWr && sel),
			.evtIdxData     (evtIdxData),
			.cmdConsume     (cmdConsume[w]),
			.evtProduce     (evtProduce[w]),
			.stCfgWr        (stCfgWr && sel),
			.stCfgData      (stCfgData),
			.stBaseWr       (stBaseWr && sel),
			.stBaseData     (stBaseData),
			.cmdQueueEnable (cmdQueueEnable[w]),
			.evtQueueEnable (evtQueueEnable[w]),
			.cmdBase        (wCb[w*64 +: 64]),
			.cmdReadIdx     (wCr[w*IDX_W +: IDX_W]),
			.cmdWriteIdx    (wCw[w*IDX_W +: IDX_W]),
			.evtBase        (wEb[w*64 +: 64]),
			.evtReadIdx     (wEr[w*IDX_W +: IDX_W]),
			.evtWriteIdx    (wEw[w*IDX_W +: IDX_W]),
			.stCfg          (wSc[w*32 +: 32]),
			.stBase         (wSb[w*64 +: 64]),
			.cmdEmpty       (wEmp_c[w]),
			.evtEmpty       (wEmp_e[w]),
			.cmdAck         (wAck_c[w]),
			.evtAck         (wAck_e[w])
		);
	end

	// ***********************************
	// output registers
	// ***********************************
	logic [1:0] next_cmdPending;
	logic       next_entryInvalid;

	always_comb begin
		next_cmdPending   = wAck_c & ~wEmp_c;
		next_entryInvalid = ~entryWord[`SQSTI_ENTRY_VALID_BIT];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmdAck         <= 2'h0;
			evtAck         <= 2'h0;
			cmdEmpty       <= 2'h3;
			evtEmpty       <= 2'h3;
			cmdPending     <= 2'h0;
			cmdReadIdx     <= '0;
			cmdWriteIdx    <= '0;
			evtReadIdx     <= '0;
			evtWriteIdx    <= '0;
			cmdBase        <= 128'h0;
			evtBase        <= 128'h0;
			stCfg          <= 64'h0;
			stBase         <= 128'h0;
			entryInvalid   <= 1'b1;
			coherentAccess <= 1'b0;
		end else begin
			cmdAck         <= wAck_c;
			evtAck         <= wAck_e;
			cmdEmpty       <= wEmp_c;
			evtEmpty       <= wEmp_e;
			cmdPending     <= next_cmdPending;
			cmdReadIdx     <= wCr;
			cmdWriteIdx    <= wCw;
			evtReadIdx     <= wEr;
			evtWriteIdx    <= wEw;
			cmdBase        <= wCb;
			evtBase        <= wEb;
			stCfg          <= wSc;
			stBase         <= wSb;
			entryInvalid   <= next_entryInvalid;
			coherentAccess <= COHERENT;
		end
	end
endmodule

// [tb/sqsti_init_regs_asserts.sv]
`timescale 1ns/1ps
module sqsti_init_regs_asserts
	import sqsti_pkg::*;
#(
	parameter int IDX_W     = 20,
	parameter int ACK_DELAY = 4,
	parameter bit COHERENT  = 1'b0
) (
	// clock and reset
	input wire logic               clock,
	input wire logic               rst_n,
	// writes
	input wire logic               secureSel,
	input wire logic               cmdBaseWr,
	input wire logic [4:0]         cmdLog2Size,
	input wire logic               cmdWriteWr,
	input wire logic [IDX_W-1:0]   cmdIdxData,
	input wire logic [63:0]        entryWord,
	input wire logic [1:0]         cmdQueueEnable,
	input wire logic [1:0]         evtQueueEnable,
	// status
	input wire logic [1:0]         cmdAck,
	input wire logic [1:0]         evtAck,
	input wire logic [1:0]         cmdEmpty,
	input wire logic [1:0]         evtEmpty,
	input wire logic [2*IDX_W-1:0] cmdReadIdx,
	input wire logic [2*IDX_W-1:0] cmdWriteIdx,
	input wire logic [2*IDX_W-1:0] evtReadIdx,
	input wire logic [2*IDX_W-1:0] evtWriteIdx,
	input wire logic               entryInvalid,
	input wire logic               coherentAccess
);
	// ****************
	// size tracking
	// ****************
	logic [4:0]       lg0;
	logic [IDX_W-1:0] mask0;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) lg0 <= 5'h00;
		else if (cmdBaseWr && !secureSel) lg0 <= cmdLog2Size;
	end
	always_comb mask0 = ~({IDX_W{1'b1}} << ((lg0 > 5'h13 ? 5'h13 : lg0) + 1));
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_cmd_idx_mask: assert property ((cmdWriteWr && !secureSel) |-> ##2
		cmdWriteIdx[IDX_W-1:0] == ($past(cmdIdxData, 2) & $past(mask0, 2))) else $error("index mask wrong");
	a_cmd_empty_eq: assert property (cmdEmpty[0] == (cmdReadIdx[IDX_W-1:0] == cmdWriteIdx[IDX_W-1:0]))
		else $error("cmd empty wrong");
	a_evt_empty_eq: assert property (evtEmpty[1] == (evtReadIdx[2*IDX_W-1:IDX_W] == evtWriteIdx[2*IDX_W-1:IDX_W]))
		else $error("evt empty wrong");
	a_entry_valid_bit: assert property (entryInvalid == !$past(entryWord[0])) else $error("entry valid wrong");
	a_coherent_fixed: assert property (coherentAccess == COHERENT) else $error("capability wrong");
	a_cmd_ack_rise: assert property ($rose(cmdAck[0]) |-> $past(cmdQueueEnable[0], 2))
		else $error("cmd ack rose early");
	a_cmd_ack_fall: assert property ($fell(cmdAck[0]) |-> !$past(cmdQueueEnable[0], 2))
		else $error("cmd ack fell early");
	a_evt_ack_rise: assert property ($rose(evtAck[1]) |-> $past(evtQueueEnable[1], 2))
		else $error("evt ack rose early");
	a_cmd_ack_reach: assert property (cmdQueueEnable[0] [*8] |-> cmdAck[0]) else $error("cmd ack late");
	a_evt_ack_reach: assert property (evtQueueEnable[1] [*8] |-> evtAck[1]) else $error("evt ack late");
	c_cmd_ack: cover property ($rose(cmdAck[0]));
	c_evt_ack: cover property ($rose(evtAck[1]));
	c_idx_wr: cover property (cmdWriteWr && !secureSel);
endmodule
bind sqsti_init_regs sqsti_init_regs_asserts #(.IDX_W(IDX_W), .ACK_DELAY(ACK_DELAY), .COHERENT(COHERENT)) chk (
	.clock(clock), .rst_n(rst_n), .secureSel(secureSel), .cmdBaseWr(cmdBaseWr), .cmdLog2Size(cmdLog2Size),
	.cmdWriteWr(cmdWriteWr), .cmdIdxData(cmdIdxData), .entryWord(entryWord), .cmdQueueEnable(cmdQueueEnable),
	.evtQueueEnable(evtQueueEnable), .cmdAck(cmdAck), .evtAck(evtAck), .cmdEmpty(cmdEmpty), .evtEmpty(evtEmpty),
	.cmdReadIdx(cmdReadIdx), .cmdWriteIdx(cmdWriteIdx), .evtReadIdx(evtReadIdx), .evtWriteIdx(evtWriteIdx),
	.entryInvalid(entryInvalid), .coherentAccess(coherentAccess));

// [tb/smmu_queue_stream_table_init_bench.sv]
`timescale 1ns/1ps
module smmu_queue_stream_table_init_bench;
	import sqsti_pkg::*;
	localparam int AD = 4;
	logic clock, rst_n, sec;
	logic [11:0]  strb;
	logic [63:0]  d, entry;
	logic [4:0]   lg;
	logic [1:0]   cmdEn, evtEn, cmdAck, evtAck, cmdEmpty, evtEmpty, cmdPending;
	logic [39:0]  cmdReadIdx, cmdWriteIdx, evtReadIdx, evtWriteIdx;
	logic [127:0] cmdBase, evtBase, stBase;
	logic [63:0]  stCfg;
	logic         entryInvalid, coherentAccess;
	int           errors, checkCount, cycles;
	sqsti_init_regs #(.IDX_W(20), .ACK_DELAY(AD), .COHERENT(1'b0)) dut (
		.clock(clock), .rst_n(rst_n), .secureSel(sec), .cmdBaseWr(strb[0]), .cmdBaseData(d), .cmdLog2Size(lg),
		.cmdReadWr(strb[1]), .cmdWriteWr(strb[2]), .cmdIdxData(d[19:0]), .evtBaseWr(strb[3]), .evtBaseData(d),
		.evtLog2Size(lg), .evtReadWr(strb[4]), .evtWriteWr(strb[5]), .evtIdxData(d[19:0]),
		.cmdConsume(strb[9:8]), .evtProduce(strb[11:10]), .stCfgWr(strb[6]), .stCfgData(d[31:0]),
		.stBaseWr(strb[7]), .stBaseData(d), .entryWord(entry), .cmdQueueEnable(cmdEn), .evtQueueEnable(evtEn),
		.cmdAck(cmdAck), .evtAck(evtAck), .cmdEmpty(cmdEmpty), .evtEmpty(evtEmpty), .cmdPending(cmdPending),
		.cmdReadIdx(cmdReadIdx), .cmdWriteIdx(cmdWriteIdx), .evtReadIdx(evtReadIdx), .evtWriteIdx(evtWriteIdx),
		.cmdBase(cmdBase), .evtBase(evtBase), .stCfg(stCfg), .stBase(stBase), .entryInvalid(entryInvalid),
		.coherentAccess(coherentAccess));
	// ****************
	// clock and tasks
	// ****************
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input int b, input logic [63:0] v);
		@(posedge clock);
		d <= v;
		strb[b] <= 1'b1;
		@(posedge clock);
		strb[b] <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic enq(input bit isEvt, input int w, input logic val);
		int n;
		n = 0;
		@(posedge clock);
		if (isEvt) evtEn[w] <= val;
		else cmdEn[w] <= val;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (n < 20 && (isEvt ? evtAck[w] : cmdAck[w]) !== val);
		chk(n, AD + 2);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			end_sim();
		end
	end
	// ****************
	// sequence
	// ****************
	initial begin
		rst_n = 1'b0;
		sec = 1'b0;
		strb = 12'h000;
		d = 64'h0;
		entry = 64'h0;
		lg = 5'h00;
		cmdEn = 2'h0;
		evtEn = 2'h0;
		errors = 0;
		checkCount = 0;
		cycles = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk(cmdAck, 2'h0);
		chk({cmdEmpty, evtEmpty}, 4'hf);
		chk(cmdReadIdx, 40'h0);
		chk(entryInvalid, 1'b1);
		chk(coherentAccess, 1'b0);
		@(posedge clock) lg <= 5'h03;
		wr(0, 64'h0000_0012_3456_7000);
		chk(cmdBase, {64'h0, 64'h0000_0012_3456_7000});
		wr(2, 64'h25);
		chk(cmdWriteIdx[19:0], 20'h00005);
		chk(cmdEmpty[0], 1'b0);
		wr(8, 64'h0);
		chk(cmdReadIdx[19:0], 20'h00000);
		enq(0, 0, 1'b1);
		wr(8, 64'h0);
		chk(cmdReadIdx[19:0], 20'h00001);
		chk(cmdPending[0], 1'b1);
		wr(1, 64'h15);
		chk({cmdEmpty[0], cmdPending[0]}, 2'h2);
		wr(8, 64'h0);
		chk(cmdReadIdx[19:0], 20'h00005);
		@(posedge clock) lg <= 5'h1f;
		wr(0, 64'h0000_0000_0008_0000);
		wr(2, 64'hfffff);
		chk(cmdWriteIdx[19:0], 20'hfffff);
		enq(0, 0, 1'b0);
		@(posedge clock);
		sec <= 1'b1;
		lg <= 5'h00;
		wr(3, 64'h0000_00ab_cdef_0000);
		chk(evtBase, {64'h0000_00ab_cdef_0000, 64'h0});
		wr(4, 64'h3);
		chk(evtReadIdx, {20'h00001, 20'h0});
		chk(evtEmpty, 2'h1);
		enq(1, 1, 1'b1);
		wr(11, 64'h0);
		chk({evtWriteIdx[39:20], evtEmpty[1]}, {20'h00001, 1'b1});
		wr(11, 64'h0);
		chk(evtWriteIdx[39:20], 20'h00000);
		@(posedge clock);
		evtEn[0] <= 1'b1;
		repeat (2) @(posedge clock);
		evtEn[0] <= 1'b0;
		repeat (10) @(posedge clock);
		#1;
		chk(evtAck, 2'h2);
		@(posedge clock) sec <= 1'b0;
		wr(6, 64'h0000_0abc);
		wr(7, 64'h0000_0044_0000_0000);
		chk({stCfg[31:0], stBase[63:0]}, {32'h0000_0abc, 64'h0000_0044_0000_0000});
		@(posedge clock);
		entry <= 64'h1;
		repeat (2) @(posedge clock);
		#1;
		chk(entryInvalid, 1'b0);
		@(posedge clock);
		entry <= 64'hfffe;
		repeat (2) @(posedge clock);
		#1;
		chk(entryInvalid, 1'b1);
		end_sim();
	end
endmodule
